// *** core/asd_consts.svh ***
// Register map, field positions, reset values and fixed counts of the audio frame decoder
`ifndef ASD_CONSTS_SVH
`define ASD_CONSTS_SVH
// ************************************************************
// Register byte addresses
// ************************************************************
`define ASD_ADDR_CTRL 12'h000
`define ASD_ADDR_FRAMING 12'h004
`define ASD_ADDR_WORD 12'h008
`define ASD_ADDR_SAMPLE 12'h00C
`define ASD_ADDR_STATUS 12'h010
// ************************************************************
// Field positions
// ************************************************************
`define ASD_CTRL_VARIANT 2:0
`define ASD_CTRL_LSB_FIRST 3
`define ASD_CTRL_RIGHT_LEADS 4
`define ASD_CTRL_FALL_EDGE 5
`define ASD_CTRL_LOW_IS_ONE 6
`define ASD_CTRL_SIDE_INVERT 7
`define ASD_FR_SLOT_LEN 7:0
`define ASD_FR_CHAN_OFFSET 15:8
`define ASD_FR_FRAME_DELAY 23:16
`define ASD_FR_SLOTS 27:24
`define ASD_WD_BITS 5:0
`define ASD_ST_CHAN 2:0
`define ASD_ST_ARMED 3
`define ASD_ST_FRAMES 31:16
// ************************************************************
// Reset values and fixed counts
// ************************************************************
`define ASD_RST_SLOT_LEN 8'h08
`define ASD_RST_CHAN_OFFSET 8'h01
`define ASD_RST_FRAME_DELAY 8'h00
`define ASD_RST_SLOTS 4'h8
`define ASD_RST_WORD_BITS 6'h08
`define ASD_MAX_SLOTS 4'h8
`define ASD_MAX_WORD_BITS 6'h20
`define ASD_STD_LEAD 8'h01
`define ASD_OPEN_SLOT 8'hFF
`define ASD_POS_MAX 8'hFF
`define ASD_DSP_SLOTS 4'h2
`define ASD_ONE_SLOT 4'h1
`endif

// *** core/asd_frame_decoder.sv ***
// Serial audio receive decoder with APB configuration and status registers
`include "asd_consts.svh"
module asd_frame_decoder (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire asd_pkg::asd_word_t pwdata,
  output asd_pkg::asd_word_t prdata,
  output logic pready,
  output logic pslverr,
  input wire logic linkClk,
  input wire logic linkWs,
  input wire logic linkData,
  output logic sampleValid,
  output asd_pkg::asd_word_t sampleWord,
  output asd_pkg::asd_chan_t sampleChannel,
  output logic frameStart
);
  import asd_pkg::*;

  // ************************************************************
  // Reset release
  // ************************************************************
  logic [1:0] rstPipe;
  logic rstn;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rstPipe <= 2'h0;
    end
    else
    begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end

  assign rstn = rstPipe[1];

  // ************************************************************
  // Link pins
  // ************************************************************
  logic clkLevel;
  logic wsLevel;
  logic dataLevel;

  asd_sync3 uSyncClk (
    .core_clk(core_clk),
    .rstn(rstn),
    .pinIn(linkClk),
    .level(clkLevel)
  );

  asd_sync3 uSyncWs (
    .core_clk(core_clk),
    .rstn(rstn),
    .pinIn(linkWs),
    .level(wsLevel)
  );

  asd_sync3 uSyncData (
    .core_clk(core_clk),
    .rstn(rstn),
    .pinIn(linkData),
    .level(dataLevel)
  );

  // ************************************************************
  // Configuration and state
  // ************************************************************
  asd_variant_e variant;
  logic bottom_bit_leads;
  logic rightLeads;
  logic fallEdge;
  logic lowIsOne;
  logic sideInvert;
  logic [7:0] slotLen;
  logic [7:0] chanOffset;
  logic [7:0] frameDelay;
  logic [3:0] slotsPerFrame;
  asd_bits_t wordBits;
  asd_word_t lastWord;
  asd_chan_t lastChan;
  logic [15:0] frameCount;
  logic armed;
  logic clkPrev;
  logic wsPrev;
  logic [7:0] pos;
  logic [7:0] slotBit;
  logic [3:0] slotIdx;
  asd_word_t shiftReg;

  // ************************************************************
  // APB decode
  // ************************************************************
  logic hitCtrl;
  logic hitFraming;
  logic hitWord;
  logic hitSample;
  logic hitStatus;
  logic hitAny;
  logic setupPhase;
  logic wrAccess;
  logic wrCtrl;
  logic wrFraming;
  logic wrWord;
  asd_word_t ctrlView;
  asd_word_t framingView;
  asd_word_t wordView;
  asd_word_t statusView;
  asd_word_t readMux;
  logic [2:0] newVariant;
  logic [3:0] newSlots;
  asd_bits_t newBits;
  logic variantOk;
  logic slotsOk;
  logic bitsOk;

  assign hitCtrl = (paddr == `ASD_ADDR_CTRL);
  assign hitFraming = (paddr == `ASD_ADDR_FRAMING);
  assign hitWord = (paddr == `ASD_ADDR_WORD);
  assign hitSample = (paddr == `ASD_ADDR_SAMPLE);
  assign hitStatus = (paddr == `ASD_ADDR_STATUS);
  assign hitAny = hitCtrl | hitFraming | hitWord | hitSample | hitStatus;
  assign setupPhase = psel & ~penable;
  assign wrAccess = psel & penable & pwrite & pready & ~pslverr;
  assign wrCtrl = wrAccess & hitCtrl;
  assign wrFraming = wrAccess & hitFraming;
  assign wrWord = wrAccess & hitWord;

  assign newVariant = pwdata[`ASD_CTRL_VARIANT];
  assign variantOk = (newVariant == ASD_VAR_STANDARD) | (newVariant == ASD_VAR_LEFT_ALIGNED)
                   | (newVariant == ASD_VAR_RIGHT_ALIGNED) | (newVariant == ASD_VAR_TDM)
                   | (newVariant == ASD_VAR_DSP);
  assign newSlots = pwdata[`ASD_FR_SLOTS];
  assign slotsOk = (newSlots != 4'h0) & (newSlots <= `ASD_MAX_SLOTS);
  assign newBits = pwdata[`ASD_WD_BITS];
  assign bitsOk = (newBits != 6'h00) & (newBits <= `ASD_MAX_WORD_BITS);

  always_comb
  begin
    ctrlView = 32'h0000_0000;
    ctrlView[`ASD_CTRL_VARIANT] = variant;
    ctrlView[`ASD_CTRL_LSB_FIRST] = bottom_bit_leads;
    ctrlView[`ASD_CTRL_RIGHT_LEADS] = rightLeads;
    ctrlView[`ASD_CTRL_FALL_EDGE] = fallEdge;
    ctrlView[`ASD_CTRL_LOW_IS_ONE] = lowIsOne;
    ctrlView[`ASD_CTRL_SIDE_INVERT] = sideInvert;
    framingView = 32'h0000_0000;
    framingView[`ASD_FR_SLOT_LEN] = slotLen;
    framingView[`ASD_FR_CHAN_OFFSET] = chanOffset;
    framingView[`ASD_FR_FRAME_DELAY] = frameDelay;
    framingView[`ASD_FR_SLOTS] = slotsPerFrame;
    wordView = 32'h0000_0000;
    wordView[`ASD_WD_BITS] = wordBits;
    statusView = 32'h0000_0000;
    statusView[`ASD_ST_CHAN] = lastChan;
    statusView[`ASD_ST_ARMED] = armed;
    statusView[`ASD_ST_FRAMES] = frameCount;
  end

  assign readMux = hitCtrl ? ctrlView
                 : hitFraming ? framingView
                 : hitWord ? wordView
                 : hitSample ? lastWord
                 : hitStatus ? statusView
                 : 32'h0000_0000;

  // Answer is ready in the first access cycle, so no wait states
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setupPhase;
      pslverr <= setupPhase & ~hitAny;
      if (setupPhase)
      begin
        prdata <= readMux;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      variant <= ASD_VAR_STANDARD;
      bottom_bit_leads <= 1'b0;
      rightLeads <= 1'b0;
      fallEdge <= 1'b0;
      lowIsOne <= 1'b0;
      sideInvert <= 1'b0;
    end
    else if (wrCtrl)
    begin
      if (variantOk)
      begin
        variant <= asd_variant_e'(newVariant);
      end
      bottom_bit_leads <= pwdata[`ASD_CTRL_LSB_FIRST];
      rightLeads <= pwdata[`ASD_CTRL_RIGHT_LEADS];
      fallEdge <= pwdata[`ASD_CTRL_FALL_EDGE];
      lowIsOne <= pwdata[`ASD_CTRL_LOW_IS_ONE];
      sideInvert <= pwdata[`ASD_CTRL_SIDE_INVERT];
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      slotLen <= `ASD_RST_SLOT_LEN;
      chanOffset <= `ASD_RST_CHAN_OFFSET;
      frameDelay <= `ASD_RST_FRAME_DELAY;
      slotsPerFrame <= `ASD_RST_SLOTS;
      wordBits <= `ASD_RST_WORD_BITS;
    end
    else
    begin
      if (wrFraming)
      begin
        slotLen <= pwdata[`ASD_FR_SLOT_LEN];
        chanOffset <= pwdata[`ASD_FR_CHAN_OFFSET];
        frameDelay <= pwdata[`ASD_FR_FRAME_DELAY];
        if (slotsOk)
        begin
          slotsPerFrame <= newSlots;
        end
      end
      if (wrWord & bitsOk)
      begin
        wordBits <= newBits;
      end
    end
  end

  // ************************************************************
  // Bit timing and framing
  // ************************************************************
  logic clkRise;
  logic clkFall;
  logic sampleEn;
  logic bitIn;
  logic wsEff;
  logic isStd;
  logic isLeft;
  logic isRight;
  logic isTdm;
  logic isDsp;
  logic framed;
  logic wsChange;
  logic syncEdge;
  logic boundary;
  logic cfgWrite;
  asd_bits_t wordEff;
  logic [7:0] curSlotLen;
  logic [3:0] curSlots;
  logic [7:0] wordStart;
  logic [8:0] wordEnd;
  logic [7:0] posCur;
  logic [7:0] sbCur;
  logic [3:0] slotCur;
  logic inFrame;
  logic inWindow;
  logic captureBit;
  logic lastBit;
  logic rightEmit;
  logic emit;
  logic newFrame;
  asd_word_t shiftIn;
  asd_word_t extractSrc;
  asd_word_t extracted;
  asd_chan_t emitChan;

  assign clkRise = clkLevel & ~clkPrev;
  assign clkFall = ~clkLevel & clkPrev;
  // Transmitter keeps data steady around this edge, so one look suffices
  assign sampleEn = fallEdge ? clkFall : clkRise;
  assign bitIn = dataLevel ^ lowIsOne;
  assign wsEff = wsLevel ^ sideInvert;

  assign isStd = (variant == ASD_VAR_STANDARD);
  assign isLeft = (variant == ASD_VAR_LEFT_ALIGNED);
  assign isRight = (variant == ASD_VAR_RIGHT_ALIGNED);
  assign isTdm = (variant == ASD_VAR_TDM);
  assign isDsp = (variant == ASD_VAR_DSP);
  assign framed = isTdm | isDsp;

  // Every select toggle opens a channel block in the two-side formats
  assign wsChange = sampleEn & (wsEff != wsPrev);
  assign syncEdge = sampleEn & wsEff & ~wsPrev;
  assign boundary = framed ? syncEdge : wsChange;
  assign newFrame = framed ? syncEdge : (wsChange & (wsEff == rightLeads));
  assign cfgWrite = wrCtrl | wrFraming | wrWord;

  // Word width never exceeds the slot length in multiplexed mode
  assign wordEff = (isTdm & ({2'h0, wordBits} > slotLen)) ? slotLen[5:0] : wordBits;
  assign curSlotLen = isTdm ? slotLen : isDsp ? {2'h0, wordEff} : `ASD_OPEN_SLOT;
  assign curSlots = isTdm ? slotsPerFrame : isDsp ? `ASD_DSP_SLOTS : `ASD_ONE_SLOT;
  assign wordStart = isStd ? `ASD_STD_LEAD
                   : (isTdm | isLeft) ? chanOffset
                   : 8'h00;
  assign wordEnd = {1'b0, wordStart} + {3'h0, wordEff};

  assign posCur = boundary ? 8'h00 : pos;
  assign sbCur = boundary ? 8'h00 : slotBit;
  assign slotCur = boundary ? 4'h0 : slotIdx;
  assign inFrame = (posCur >= frameDelay);
  assign inWindow = inFrame & (slotCur < curSlots) & (sbCur >= wordStart)
                  & ({1'b0, sbCur} < wordEnd);
  assign captureBit = sampleEn & armed & inWindow & ~isRight & ~cfgWrite;
  assign lastBit = captureBit & ({1'b0, sbCur} == (wordEnd - 9'h001));
  // Right aligned: the bits just before the toggle make the word
  assign rightEmit = isRight & boundary & armed & ~cfgWrite;
  assign emit = lastBit | rightEmit;

  assign shiftIn = bottom_bit_leads ? {bitIn, shiftReg[31:1]} : {shiftReg[30:0], bitIn};
  assign extractSrc = isRight ? shiftReg : shiftIn;
  assign emitChan = framed ? slotCur[2:0] : {2'h0, isRight ? wsPrev : wsEff};

  asd_word_extract uExtract (
    .bits(extractSrc),
    .width(wordEff),
    .bottom_bit_leads(bottom_bit_leads),
    .word(extracted)
  );

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      clkPrev <= 1'b0;
      wsPrev <= 1'b0;
    end
    else
    begin
      clkPrev <= clkLevel;
      if (sampleEn)
      begin
        wsPrev <= wsEff;
      end
    end
  end

  // Any change of settings drops sync until the next block start
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      armed <= 1'b0;
    end
    else if (boundary)
    begin
      // A block start in the same cycle as a write still arms
      armed <= 1'b1;
    end
    else if (cfgWrite)
    begin
      armed <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pos <= 8'h00;
      slotBit <= 8'h00;
      slotIdx <= 4'h0;
    end
    else if (sampleEn)
    begin
      pos <= (posCur == `ASD_POS_MAX) ? posCur : posCur + 8'h01;
      if (inFrame)
      begin
        if (sbCur == (curSlotLen - 8'h01))
        begin
          slotBit <= 8'h00;
          slotIdx <= (slotCur < curSlots) ? slotCur + 4'h1 : slotCur;
        end
        else
        begin
          slotBit <= sbCur + 8'h01;
          slotIdx <= slotCur;
        end
      end
      else
      begin
        slotBit <= sbCur;
        slotIdx <= slotCur;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      shiftReg <= 32'h0000_0000;
    end
    else if (captureBit | (sampleEn & isRight))
    begin
      shiftReg <= shiftIn;
    end
  end

  // ************************************************************
  // Results
  // ************************************************************
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sampleValid <= 1'b0;
      sampleWord <= 32'h0000_0000;
      sampleChannel <= 3'h0;
      frameStart <= 1'b0;
      lastWord <= 32'h0000_0000;
      lastChan <= 3'h0;
      frameCount <= 16'h0000;
    end
    else
    begin
      sampleValid <= emit;
      frameStart <= newFrame & ~cfgWrite;
      if (emit)
      begin
        sampleWord <= extracted;
        sampleChannel <= emitChan;
        lastWord <= extracted;
        lastChan <= emitChan;
      end
      if (newFrame & ~cfgWrite)
      begin
        frameCount <= frameCount + 16'h0001;
      end
    end
  end
endmodule

// *** core/asd_pkg.sv ***
// Types shared by the audio frame decoder files
package asd_pkg;
  typedef enum logic [2:0] {
    ASD_VAR_STANDARD = 3'h0,
    ASD_VAR_LEFT_ALIGNED = 3'h1,
    ASD_VAR_RIGHT_ALIGNED = 3'h3,
    ASD_VAR_TDM = 3'h2,
    ASD_VAR_DSP = 3'h6
  } asd_variant_e;
  typedef logic [31:0] asd_word_t;
  typedef logic [2:0] asd_chan_t;
  typedef logic [5:0] asd_bits_t;
endpackage

// *** core/asd_sync3.sv ***
// Three-stage synchroniser that moves its output only when stages two and three agree
module asd_sync3 (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic pinIn,
  output logic level
);
  logic stage1;
  logic stage2;
  logic stage3;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level <= 1'b0;
    end
    else
    begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3)
      begin
        level <= stage3;
      end
    end
  end
endmodule

// *** core/asd_word_extract.sv ***
// Picks the audio word out of the shift register and sign-extends it
`include "asd_consts.svh"
module asd_word_extract (
  input wire asd_pkg::asd_word_t bits,
  input wire asd_pkg::asd_bits_t width,
  input wire logic bottom_bit_leads,
  output asd_pkg::asd_word_t word
);
  import asd_pkg::*;
  asd_bits_t shiftAmt;
  asd_word_t aligned;
  asd_word_t mask;
  asd_word_t signBit;
  asd_word_t value;

  // Bottom-first words collect at the top of the register
  assign shiftAmt = `ASD_MAX_WORD_BITS - width;
  assign aligned = bottom_bit_leads ? (bits >> shiftAmt) : bits;
  assign mask = (width == `ASD_MAX_WORD_BITS) ? ~32'h0000_0000
              : ((32'h0000_0001 << width) - 32'h0000_0001);
  assign signBit = 32'h0000_0001 << (width - 6'h01);
  assign value = aligned & mask;
  // Two's complement over the configured width
  assign word = (value ^ signBit) - signBit;
endmodule

// *** verification/asd_frame_decoder_monitor.sv ***
// Port-level assertions for the audio frame decoder
module asd_frame_decoder_monitor (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire asd_pkg::asd_word_t prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic linkClk,
  input wire logic sampleValid,
  input wire asd_pkg::asd_word_t sampleWord,
  input wire asd_pkg::asd_chan_t sampleChannel,
  input wire logic frameStart
);
  import asd_pkg::*;
  logic prevClk;
  logic [4:0] sinceEdge;
  wire logic unmapped;
  // Only aligned words from CTRL up to STATUS decode
  assign unmapped = (paddr[1:0] != 2'h0) || (paddr > 12'h010);
  // Saturates so a long idle link never wraps back into the allowed window
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prevClk <= 1'b0;
      sinceEdge <= 5'h1F;
    end
    else
    begin
      prevClk <= linkClk;
      sinceEdge <= (linkClk != prevClk) ? 5'h00 : sinceEdge + {4'h0, sinceEdge != 5'h1F};
    end
  end
  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking mon @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  chk_ready_follows: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_decode: assert property (pready |-> pslverr == unmapped)
    else $error("pslverr does not match address decode");
  chk_err_quiet: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("refused access returned data");
  chk_valid_pulse: assert property (sampleValid |=> !sampleValid)
    else $error("sampleValid longer than one cycle");
  chk_frame_pulse: assert property (frameStart |=> !frameStart)
    else $error("frameStart longer than one cycle");
  chk_word_hold: assert property (!sampleValid |-> $stable(sampleWord) && $stable(sampleChannel))
    else $error("sample output moved without sampleValid");
  chk_valid_link: assert property (sampleValid |-> sinceEdge <= 5'h0A)
    else $error("word decoded with no link clock edge");
  chk_frame_link: assert property (frameStart |-> sinceEdge <= 5'h0A)
    else $error("frame start with no link clock edge");
endmodule

// *** verification/asd_frame_decoder_tb.sv ***
// Self-checking bench for the audio frame decoder
`include "asd_consts.svh"
module asd_frame_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import asd_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  asd_word_t pwdata = 32'h0000_0000;
  asd_word_t prdata;
  asd_word_t sampleWord;
  asd_chan_t sampleChannel;
  logic pready;
  logic pslverr;
  logic linkClk;
  logic linkWs;
  logic linkData;
  logic sampleValid;
  logic frameStart;
  int miscompares = 0;
  int totalChecks = 0;
  int frames = 0;
  asd_word_t gotWord[$];
  asd_chan_t gotChan[$];
  bit wsQ[$];
  bit dQ[$];
  asd_word_t vals[4] = '{32'h0000_0021, 32'h0000_001F, 32'h0000_003A, 32'h0000_0005};
  always #5 core_clk = ~core_clk;
  asd_frame_decoder DUT (.core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .linkClk, .linkWs, .linkData, .sampleValid, .sampleWord,
    .sampleChannel, .frameStart);
  asd_link_tx link (.linkClk, .linkWs, .linkData);
  always @(posedge core_clk)
  begin
    if (sampleValid === 1'b1)
    begin
      gotWord.push_back(sampleWord);
      gotChan.push_back(sampleChannel);
    end
    if (frameStart === 1'b1)
      frames++;
  end
  task automatic closeOut();
    $display("checks %0d, mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic giveUp(input string msg);
    miscompares++;
    $display("wrong value at %0t: %s", $time, msg);
    closeOut();
  endtask
  task automatic compare(input asd_word_t got, input asd_word_t exp);
    totalChecks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic isWr, input logic [11:0] a, input asd_word_t wd,
    output asd_word_t rd, output logic err);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= isWr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
      giveUp("no pready");
  endtask
  task automatic regWr(input logic [11:0] a, input asd_word_t d);
    asd_word_t rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask
  task automatic regRd(input logic [11:0] a, input asd_word_t exp, input logic errExp);
    asd_word_t rd;
    logic err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    compare(rd, exp);
    compare({31'h0, err}, {31'h0, errExp});
  endtask
  function automatic asd_word_t sx(input asd_word_t w, input int nb);
    asd_word_t m;
    m = 32'hFFFF_FFFF << nb;
    return w[nb - 1] ? (w | m) : (w & ~m);
  endfunction
  // Padding bits are ones, so a misplaced word window shows up in the value
  task automatic block(input bit ws0, input bit ws1, input asd_word_t w, input int len,
    input int pos, input int nb, input logic [7:0] ctrl);
    int k;
    for (int i = 0; i < len; i++)
    begin
      k = ctrl[3] ? i - pos : pos + nb - 1 - i;
      wsQ.push_back((i == 0 ? ws0 : ws1) ^ ctrl[7]);
      dQ.push_back((i >= pos && i < pos + nb ? w[k] : 1'b1) ^ ctrl[6]);
    end
  endtask
  task automatic checkWord(input int back, input asd_word_t w, input int c);
    compare(gotWord[gotWord.size() - back], w);
    compare({29'h0, gotChan[gotChan.size() - back]}, c);
  endtask
  task automatic launch(input logic [7:0] ctrl, input int n);
    link.send(wsQ, dQ, ctrl[5]);
    for (int i = 0; i < 64 && gotWord.size() < n; i++)
      @(posedge core_clk);
    if (gotWord.size() < n)
      giveUp("too few words");
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic regScenario();
    regRd(`ASD_ADDR_CTRL, 32'h0000_0000, 1'b0);
    regRd(`ASD_ADDR_FRAMING, 32'h0800_0108, 1'b0);
    regRd(`ASD_ADDR_WORD, 32'h0000_0008, 1'b0);
    regRd(`ASD_ADDR_STATUS, 32'h0000_0000, 1'b0);
    regRd(12'h014, 32'h0000_0000, 1'b1);
    regRd(12'h002, 32'h0000_0000, 1'b1);
    regWr(`ASD_ADDR_CTRL, 32'h0000_000D);
    regRd(`ASD_ADDR_CTRL, 32'h0000_0008, 1'b0);
    regWr(`ASD_ADDR_WORD, 32'h0000_0021);
    regRd(`ASD_ADDR_WORD, 32'h0000_0008, 1'b0);
    regWr(`ASD_ADDR_SAMPLE, 32'hFFFF_FFFF);
    regRd(`ASD_ADDR_SAMPLE, 32'h0000_0000, 1'b0);
  endtask
  task automatic twoSide(input logic [7:0] ctrl, input asd_word_t lw, input asd_word_t rw);
    int pos;
    pos = ctrl[2:0] == 3'h0 ? 1 : 2;
    regWr(`ASD_ADDR_CTRL, {24'h0, ctrl});
    wsQ.delete();
    dQ.delete();
    gotWord.delete();
    gotChan.delete();
    frames = 0;
    block(1'b1, 1'b1, 32'h0000_0000, 2, 0, 0, ctrl);
    repeat (2)
    begin
      block(1'b0, 1'b0, lw, 10, pos, 8, ctrl);
      block(1'b1, 1'b1, rw, 10, pos, 8, ctrl);
    end
    block(1'b0, 1'b0, 32'h0000_0000, 2, 0, 0, ctrl);
    launch(ctrl, 2);
    checkWord(2, sx(lw, 8), 0);
    checkWord(1, sx(rw, 8), 1);
    compare(frames, 3);
  endtask
  task automatic multiSlot(input logic [7:0] ctrl, input int dly, input int sl, input int off,
    input int nsl, input int nb);
    regWr(`ASD_ADDR_FRAMING, {4'h0, nsl[3:0], dly[7:0], off[7:0], sl[7:0]});
    regWr(`ASD_ADDR_WORD, asd_word_t'(nb));
    regWr(`ASD_ADDR_CTRL, {24'h0, ctrl});
    wsQ.delete();
    dQ.delete();
    gotWord.delete();
    gotChan.delete();
    frames = 0;
    block(1'b0, 1'b0, 32'h0000_0000, 2, 0, 0, ctrl);
    repeat (2)
      for (int s = 0; s < nsl; s++)
        block(s == 0, 1'b0, vals[s], s == 0 ? dly + sl : sl, s == 0 ? dly + off : off, nb, ctrl);
    block(1'b1, 1'b0, 32'h0000_0000, 2, 0, 0, ctrl);
    launch(ctrl, nsl);
    for (int s = 0; s < nsl; s++)
      checkWord(nsl - s, sx(vals[s], nb), s);
    compare(frames, 3);
  endtask
  initial
  begin
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    regScenario();
    twoSide(8'h00, 32'h0000_0096, 32'h0000_0035);
    // Offset of two sets the left aligned word apart from the standard lead bit
    regWr(`ASD_ADDR_FRAMING, 32'h0800_0208);
    twoSide(8'h01, 32'h0000_0096, 32'h0000_0035);
    twoSide(8'h03, 32'h0000_0035, 32'h0000_00C3);
    twoSide(8'hF8, 32'h0000_0096, 32'h0000_0035);
    multiSlot(8'h02, 2, 8, 1, 4, 6);
    multiSlot(8'h8A, 2, 8, 1, 4, 6);
    multiSlot(8'h06, 0, 6, 0, 2, 6);
    // Seven scenarios of three frame starts each, last word from slot one
    regRd(`ASD_ADDR_STATUS, 32'h0015_0009, 1'b0);
    regRd(`ASD_ADDR_SAMPLE, 32'h0000_001F, 1'b0);
    closeOut();
  end
endmodule
bind asd_frame_decoder asd_frame_decoder_monitor mon (.core_clk, .resetn, .psel, .penable,
  .paddr, .prdata, .pready, .pslverr, .linkClk, .sampleValid, .sampleWord, .sampleChannel,
  .frameStart);

// *** verification/asd_link_tx.sv ***
// Serial audio transmitter model that clocks out prepared bit streams
module asd_link_tx (
  output logic linkClk,
  output logic linkWs,
  output logic linkData
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    linkClk = 1'b0;
    linkWs = 1'b0;
    linkData = 1'b0;
  end
  // Clock rests at its non-sampling level, so no edge happens between frames
  // Started on a core clock edge; non-blocking updates keep pins clear of that sample
  task automatic send(input bit ws[$], input bit d[$], input bit fall);
    linkClk <= fall;
    for (int i = 0; i < ws.size(); i++)
    begin
      linkWs <= ws[i];
      linkData <= d[i];
      #40 linkClk <= ~fall;
      #40 linkClk <= fall;
    end
    linkData <= ~linkData;
  endtask
endmodule
